// file: verilog/tft_defs.svh
// Operation
// RULE1: Multi-trace channel traces every single hit.
// RULE2: Single-trace: one message per run of matches.
// RULE3: Non-trace actions happen on every hit.
// RULE4: Trace-sent bit cleared when channel misses.
// RULE5: Match with multi or clear bit traces.
// RULE6: One shared 40-bit timestamp counter.
// RULE7: Timestamp advances through programmable prescaler.
// RULE8: Reference message before first non-printf trace.
// RULE9: Reference after 256 or more idle intervals.
// RULE10: Timestamp byte holds time since reference.
// RULE11: Trigger-in pin drives a chain-latch.
// RULE12: Manual, edge and level trigger-in modes.
// RULE13: Select codes rise, fall, level, manual.
// RULE14: Manual mode ignores channel set/clear actions.
// RULE15: Core mode pulses pin low per event.
// RULE16: Stretch pulses; ignore hits during pulse/recovery.
// RULE17: Bus analyzer mode pulses the same way.
// RULE18: Third mode follows core chain-latch zero.
// RULE19: Fourth mode follows module chain-latch zero.
// RULE20: Module chain-latch acts at capture-buffer output.
// RULE21: Fifth mode holds pin low while stalled.
// RULE22: Five-way select; pin high when idle.
// RULE23: Pulse width and recovery in clock cycles.
`ifndef TFT_DEFS_SVH
`define TFT_DEFS_SVH

// Register byte offsets
`define TFT_OFF_CTRL 8'h00
`define TFT_OFF_PRESCALE 8'h04
`define TFT_OFF_CHMODE 8'h08
`define TFT_OFF_STATUS 8'h0c
`define TFT_OFF_TSLO 8'h10
`define TFT_OFF_TSHI 8'h14
`define TFT_OFF_TRIGIN 8'h18

// Control register fields
`define TFT_CTRL_TRIN_LSB 0
`define TFT_CTRL_STALL_BIT 2
`define TFT_CTRL_TROUT_LSB 3

// Channel mode register fields
`define TFT_CHMODE_MULTI_LSB 0
`define TFT_CHMODE_TSEN_LSB 4

// Reset values
`define TFT_TRIN_RESET 2'h3
`define TFT_PRESCALE_RESET 16'h0000

// Trigger-in select codes
`define TFT_TRIN_RISE 2'h0
`define TFT_TRIN_FALL 2'h1
`define TFT_TRIN_LEVEL 2'h2
`define TFT_TRIN_MANUAL 2'h3

// Trigger-out select codes
`define TFT_TROUT_CORE 3'h0
`define TFT_TROUT_BUSAN 3'h1
`define TFT_TROUT_CCHAIN 3'h2
`define TFT_TROUT_MCHAIN 3'h3
`define TFT_TROUT_STALL 3'h4

// Timing counts: pulse in core clock cycles, reference gap in timestamp ticks
`define TFT_PULSE_CYC 8'h08
`define TFT_REF_GAP 9'h100

// AXI responses
`define TFT_RESP_OKAY 2'h0
`define TFT_RESP_SLVERR 2'h2

`endif

// file: verilog/tft_pkg.sv
package tft_pkg;
  // Timestamp word
  typedef logic [39:0] tft_ts_t;
  // Per-channel mask for the instruction-address channels
  typedef logic [3:0] tft_chan_t;
  // Pulse stretcher states
  typedef enum logic [1:0] {TFT_IDLE, TFT_DRIVE, TFT_RECOVER} tft_str_state_t;
endpackage : tft_pkg

// file: verilog/tft_pulse_if.sv
`timescale 1ns/100ps
// Event into a stretcher and its stretched active-low pulse
interface tft_pulse_if;
  logic hit;
  logic pulseN;
  modport stretch (input hit, output pulseN);
  modport user (output hit, input pulseN);
endinterface : tft_pulse_if

// file: verilog/tft_pulse_stretch.sv
`timescale 1ns/100ps
`include "tft_defs.svh"
module tft_pulse_stretch (
  input wire logic core_clk,
  input wire logic rst,
  tft_pulse_if.stretch pif
);
  import tft_pkg::*;

  tft_str_state_t state_r; // Stretcher state
  logic [7:0] cnt_r; // Cycles left in current phase
  logic last; // Last cycle of the phase
  assign last = (cnt_r == 8'h01);

  // Drive low for the width, then hold off for an equal recovery
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= TFT_IDLE;
      cnt_r <= 8'h00;
      pif.pulseN <= 1'b1;
    end
    else
    begin
      unique case (state_r)
        TFT_IDLE:
        begin
          if (pif.hit)
          begin
            state_r <= TFT_DRIVE; // see RULE16
            cnt_r <= `TFT_PULSE_CYC; // see RULE23
            pif.pulseN <= 1'b0;
          end
        end
        TFT_DRIVE:
        begin
          // Hits ignored while driving
          cnt_r <= cnt_r - 8'h01;
          if (last)
          begin
            state_r <= TFT_RECOVER; // see RULE16
            cnt_r <= `TFT_PULSE_CYC;
            pif.pulseN <= 1'b1;
          end
        end
        TFT_RECOVER:
        begin
          // Hits ignored while recovering
          cnt_r <= cnt_r - 8'h01;
          if (last)
            state_r <= TFT_IDLE;
        end
      endcase
    end
  end
endmodule : tft_pulse_stretch

// file: verilog/tft_top.sv
`timescale 1ns/100ps
`include "tft_defs.svh"
module tft_top (
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Channel matches, already qualified by preconditions
  input wire tft_pkg::tft_chan_t chanMatch,
  // Trace message emitted per channel
  output tft_pkg::tft_chan_t chanTrace,
  // Hit forwarded for counters and latch actions
  output tft_pkg::tft_chan_t chanHit,
  // Timestamp byte attached per channel message
  output tft_pkg::tft_chan_t chanTsAttach,
  // Reference message goes ahead of this cycle's traces
  output logic refMsg,
  // Timestamp byte value for this cycle's traces
  output logic [7:0] tsByte,
  // Shared timestamp
  output tft_pkg::tft_ts_t timestamp,
  // Channel actions on the trigger-in latch
  input wire logic trigInSetAct,
  input wire logic trigInClrAct,
  // Trigger-in latch state for channel preconditions
  output logic trigInLatch,
  // Trigger-in pin, sampled as synchronous
  input wire logic triggerInPinN,
  // Trigger-out event sources
  input wire logic coreTrigEvt,
  input wire logic busAnTrigEvt,
  // Core watchpoint controller chain-latch zero
  input wire logic coreChainZero,
  // Module chain-latch zero actions from capture buffer output
  input wire logic modChainSet,
  input wire logic modChainClr,
  // Processor stalled by the capture buffer
  input wire logic cpuStalled,
  // Trigger-out pin, active low
  output logic triggerOutPinN
);
  import tft_pkg::*;

  // Register storage
  logic [1:0] trinSel_r; // Trigger-in select
  logic stallMode_r; // Stall mode selected
  logic [2:0] troutSel_r; // Trigger-out function
  logic [15:0] prescale_r; // Prescaler reload
  tft_chan_t multi_r; // Multi-trace mode per channel
  tft_chan_t tsEn_r; // Timestamp enable per channel

  // AXI write side state
  logic awHeld_r; // Write address captured
  logic [7:0] awAddr_r; // Captured write address
  logic wHeld_r; // Write data captured
  logic [31:0] wData_r; // Captured write data
  logic [3:0] wStrb_r; // Captured strobes

  // Trace and timestamp state
  tft_chan_t traceSent_r; // Trace-sent bit per channel
  logic [15:0] preCnt_r; // Prescaler count
  tft_ts_t tsRef_r; // Timestamp at last reference
  logic [8:0] gapCnt_r; // Intervals since last trace, saturating
  logic seen_r; // A trace message has gone out
  logic modChain_r; // Module chain-latch zero
  logic pinPrev_r; // Trigger-in pin last cycle

  // Handshakes
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
  wire arTake = s_axi_arvalid & s_axi_arready;

  // Write decode
  wire wrCtrl = doWrite & (awAddr_r == `TFT_OFF_CTRL);
  wire wrPre = doWrite & (awAddr_r == `TFT_OFF_PRESCALE);
  wire wrMode = doWrite & (awAddr_r == `TFT_OFF_CHMODE);
  wire wrTrig = doWrite & (awAddr_r == `TFT_OFF_TRIGIN);
  wire wrRo = (awAddr_r == `TFT_OFF_STATUS) | (awAddr_r == `TFT_OFF_TSLO) | (awAddr_r == `TFT_OFF_TSHI);
  wire wrOk = wrCtrl | wrPre | wrMode | wrTrig | (doWrite & wrRo);

  // Byte-lane mask from strobes
  wire [31:0] laneMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

  // Current register words and their merged values
  wire [31:0] ctrlWord = {26'h0, troutSel_r, stallMode_r, trinSel_r};
  wire [31:0] preWord = {16'h0, prescale_r};
  wire [31:0] modeWord = {24'h0, tsEn_r, multi_r};
  wire [31:0] ctrlMerge = (ctrlWord & ~laneMask) | (wData_r & laneMask);
  wire [31:0] preMerge = (preWord & ~laneMask) | (wData_r & laneMask);
  wire [31:0] modeMerge = (modeWord & ~laneMask) | (wData_r & laneMask);
  wire trigWrVal = wData_r[0];
  wire trigWrEn = wrTrig & wStrb_r[0];

  // Read decode
  wire [31:0] statusWord = {28'h0, seen_r, triggerOutPinN, modChain_r, trigInLatch};
  wire [31:0] rdMux =
    (s_axi_araddr == `TFT_OFF_CTRL) ? ctrlWord :
    (s_axi_araddr == `TFT_OFF_PRESCALE) ? preWord :
    (s_axi_araddr == `TFT_OFF_CHMODE) ? modeWord :
    (s_axi_araddr == `TFT_OFF_STATUS) ? statusWord :
    (s_axi_araddr == `TFT_OFF_TSLO) ? timestamp[31:0] :
    (s_axi_araddr == `TFT_OFF_TSHI) ? {24'h0, timestamp[39:32]} :
    (s_axi_araddr == `TFT_OFF_TRIGIN) ? {31'h0, trigInLatch} : 32'h0;
  wire rdOk = (s_axi_araddr == `TFT_OFF_CTRL) | (s_axi_araddr == `TFT_OFF_PRESCALE)
    | (s_axi_araddr == `TFT_OFF_CHMODE) | (s_axi_araddr == `TFT_OFF_STATUS)
    | (s_axi_araddr == `TFT_OFF_TSLO) | (s_axi_araddr == `TFT_OFF_TSHI)
    | (s_axi_araddr == `TFT_OFF_TRIGIN);

  // Trace filtering
  wire [3:0] emit = chanMatch & (multi_r | ~traceSent_r); // see RULE1 see RULE2 see RULE5
  wire anyTrace = |emit;
  wire tick = (preCnt_r == prescale_r);
  wire gapFull = (gapCnt_r >= `TFT_REF_GAP);
  wire needRef = anyTrace & (~seen_r | gapFull); // see RULE8 see RULE9
  wire [39:0] sinceRef = timestamp - tsRef_r;
  wire [7:0] tsSat = (sinceRef[39:8] != 32'h0) ? 8'hff : sinceRef[7:0];

  // Trigger-in edges and select
  wire pinRise = triggerInPinN & ~pinPrev_r;
  wire pinFall = ~triggerInPinN & pinPrev_r;
  wire trinManual = (trinSel_r == `TFT_TRIN_MANUAL);

  // Pulse stretchers for the two event trigger-out modes
  tft_pulse_if corePulse ();
  tft_pulse_if busPulse ();
  assign corePulse.hit = coreTrigEvt; // see RULE15
  assign busPulse.hit = busAnTrigEvt; // see RULE17

  tft_pulse_stretch coreStretch (
    .core_clk(core_clk),
    .rst(rst),
    .pif(corePulse)
  );

  tft_pulse_stretch busStretch (
    .core_clk(core_clk),
    .rst(rst),
    .pif(busPulse)
  );

  // Trigger-out function select
  wire outNxt =
    (troutSel_r == `TFT_TROUT_CORE) ? corePulse.pulseN : // see RULE15
    (troutSel_r == `TFT_TROUT_BUSAN) ? busPulse.pulseN : // see RULE17
    (troutSel_r == `TFT_TROUT_CCHAIN) ? ~coreChainZero : // see RULE18
    (troutSel_r == `TFT_TROUT_MCHAIN) ? ~modChain_r : // see RULE19
    (troutSel_r == `TFT_TROUT_STALL) ? ~(stallMode_r & cpuStalled) : // see RULE21
    1'b1; // see RULE22

  // AXI write address and data capture, either order
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end
    else
    begin
      // Address taken, hold until the write is done
      if (awTake)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (doWrite)
        awHeld_r <= 1'b0;
      // Data taken likewise
      if (wTake)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (doWrite)
        wHeld_r <= 1'b0;
      // Reopen both channels once the response is taken
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TFT_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrOk ? `TFT_RESP_OKAY : `TFT_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel, one register of latency
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TFT_RESP_OKAY;
    end
    else if (arTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? `TFT_RESP_OKAY : `TFT_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software-written configuration
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      trinSel_r <= `TFT_TRIN_RESET; // see RULE13
      stallMode_r <= 1'b0;
      troutSel_r <= `TFT_TROUT_CORE;
      prescale_r <= `TFT_PRESCALE_RESET;
      multi_r <= 4'h0;
      tsEn_r <= 4'h0;
    end
    else
    begin
      if (wrCtrl)
      begin
        trinSel_r <= ctrlMerge[`TFT_CTRL_TRIN_LSB +: 2];
        stallMode_r <= ctrlMerge[`TFT_CTRL_STALL_BIT];
        troutSel_r <= ctrlMerge[`TFT_CTRL_TROUT_LSB +: 3]; // see RULE22
      end
      if (wrPre)
        prescale_r <= preMerge[15:0]; // see RULE7
      if (wrMode)
      begin
        multi_r <= modeMerge[`TFT_CHMODE_MULTI_LSB +: 4];
        tsEn_r <= modeMerge[`TFT_CHMODE_TSEN_LSB +: 4];
      end
    end
  end

  // Prescaler and the single shared timestamp
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      preCnt_r <= 16'h0;
      timestamp <= 40'h0;
    end
    else if (tick)
    begin
      preCnt_r <= 16'h0; // see RULE7
      timestamp <= timestamp + 40'h1; // see RULE6
    end
    else
      preCnt_r <= preCnt_r + 16'h1;
  end

  // Per-channel trace filter and hit forwarding
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      traceSent_r <= 4'h0;
      chanTrace <= 4'h0;
      chanHit <= 4'h0;
      chanTsAttach <= 4'h0;
    end
    else
    begin
      // Set while matching, cleared on any miss
      traceSent_r <= chanMatch; // see RULE4 see RULE5
      chanTrace <= emit;
      chanHit <= chanMatch; // see RULE3
      chanTsAttach <= emit & tsEn_r; // see RULE10
    end
  end

  // Reference message insertion and timestamp byte
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      seen_r <= 1'b0;
      gapCnt_r <= 9'h0;
      tsRef_r <= 40'h0;
      refMsg <= 1'b0;
      tsByte <= 8'h0;
    end
    else
    begin
      refMsg <= needRef; // see RULE8 see RULE9
      if (anyTrace)
      begin
        seen_r <= 1'b1;
        gapCnt_r <= {8'h00, tick}; // A tick on the trace cycle already counts, see RULE9
      end
      else if (tick & ~gapFull)
        gapCnt_r <= gapCnt_r + 9'h1;
      // A fresh reference restarts the byte at zero
      if (needRef)
      begin
        tsRef_r <= timestamp;
        tsByte <= 8'h0; // see RULE10
      end
      else
        tsByte <= tsSat; // see RULE10
    end
  end

  // Trigger-in chain-latch
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinPrev_r <= 1'b1; // Idle pin level, so no false edge after reset
      trigInLatch <= 1'b0;
    end
    else
    begin
      pinPrev_r <= triggerInPinN;
      if (trigWrEn)
        trigInLatch <= trigWrVal;
      else if (trinManual)
        trigInLatch <= trigInLatch; // see RULE14
      else
      begin
        unique case (trinSel_r)
          `TFT_TRIN_RISE:
            trigInLatch <= pinRise | (trigInLatch | trigInSetAct) & ~trigInClrAct; // see RULE12
          `TFT_TRIN_FALL:
            trigInLatch <= pinFall | (trigInLatch | trigInSetAct) & ~trigInClrAct; // see RULE12
          `TFT_TRIN_LEVEL:
            trigInLatch <= triggerInPinN; // see RULE11 see RULE13
          `TFT_TRIN_MANUAL:
            trigInLatch <= trigInLatch; // see RULE14
        endcase
      end
    end
  end

  // Module chain-latch zero, actions arrive at capture-buffer output
  always_ff @(posedge core_clk)
  begin
    if (rst)
      modChain_r <= 1'b0;
    else if (modChainSet)
      modChain_r <= 1'b1; // see RULE20
    else if (modChainClr)
      modChain_r <= 1'b0; // see RULE20
  end

  // Trigger-out pin register
  always_ff @(posedge core_clk)
  begin
    if (rst)
      triggerOutPinN <= 1'b1;
    else
      triggerOutPinN <= outNxt; // see RULE16 see RULE22
  end
endmodule : tft_top

// file: verif/tft_la_model.sv
`timescale 1ns/100ps
// Analyzer on the pin side: drives the trigger-in pin, times trigger-out pulses
module tft_la_model (
  input wire logic core_clk,
  input wire logic pinCmd,
  input wire logic triggerOutPinN,
  output logic triggerInPinN,
  output logic [15:0] pulseCnt,
  output logic [15:0] lastWidth
);
  logic prevOut_r = 1'h1; // Pin level at the previous edge
  logic [15:0] width_r = 16'h0; // Low cycles of the current pulse
  initial triggerInPinN = 1'h1;
  initial pulseCnt = 16'h0;
  initial lastWidth = 16'h0;
  // Change the input pin just after an edge; count and time low pulses
  always @(posedge core_clk)
  begin
    triggerInPinN <= pinCmd;
    prevOut_r <= triggerOutPinN;
    if (prevOut_r && !triggerOutPinN)
    begin
      pulseCnt <= pulseCnt + 16'h1;
      width_r <= 16'h1;
    end
    else if (!triggerOutPinN)
      width_r <= width_r + 16'h1;
    else if (!prevOut_r)
      lastWidth <= width_r;
  end
endmodule : tft_la_model

// file: verif/tft_checker.sv
`timescale 1ns/100ps
`include "tft_defs.svh"
// Port-level checks; control writes are snooped to know the modes
module tft_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire tft_pkg::tft_chan_t chanMatch,
  input wire tft_pkg::tft_chan_t chanTrace,
  input wire tft_pkg::tft_chan_t chanHit,
  input wire tft_pkg::tft_chan_t chanTsAttach,
  input wire logic refMsg,
  input wire logic [7:0] tsByte,
  input wire tft_pkg::tft_ts_t timestamp,
  input wire logic trigInLatch,
  input wire logic triggerInPinN,
  input wire logic coreChainZero,
  input wire logic cpuStalled,
  input wire logic triggerOutPinN
);
  import tft_pkg::*;
  // Address and data taken together
  wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ctrlWr = wrTake && s_axi_awaddr == `TFT_OFF_CTRL;
  wire trigWr = wrTake && s_axi_awaddr == `TFT_OFF_TRIGIN;
  logic [2:0] outSel_r; // Trigger-out select mirror
  logic [1:0] inSel_r; // Trigger-in select mirror
  logic stall_r; // Stall mode mirror
  tft_chan_t prevMatch_r; // Match of the last cycle
  wire tft_chan_t runStart = chanMatch & ~prevMatch_r;
  // Mirror the mode fields
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      outSel_r <= `TFT_TROUT_CORE;
      inSel_r <= `TFT_TRIN_RESET;
      stall_r <= 1'h0;
      prevMatch_r <= '0;
    end
    else
    begin
      prevMatch_r <= chanMatch;
      if (ctrlWr)
      begin
        outSel_r <= s_axi_wdata[5:3];
        inSel_r <= s_axi_wdata[1:0];
        stall_r <= s_axi_wdata[2];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_hit; !$past(rst) |-> chanHit == $past(chanMatch); endproperty
  a_hit: assert property (p_hit) else $error("hit lost");
  property p_run; runStart != '0 |=> (chanTrace & $past(runStart)) == $past(runStart); endproperty
  a_run: assert property (p_run) else $error("new run untraced");
  property p_onmatch; !$past(rst) |-> (chanTrace & ~$past(chanMatch)) == '0; endproperty
  a_onmatch: assert property (p_onmatch) else $error("trace without match");
  property p_ref; refMsg |-> chanTrace != '0; endproperty
  a_ref: assert property (p_ref) else $error("lone reference");
  property p_tsref; refMsg |-> tsByte == 8'h00 && (chanTsAttach & ~chanTrace) == '0; endproperty
  a_tsref: assert property (p_tsref) else $error("timestamp byte");
  property p_step; !$past(rst) |-> timestamp == $past(timestamp) || timestamp == $past(timestamp) + 40'h1; endproperty
  a_step: assert property (p_step) else $error("timestamp jump");
  property p_width; $fell(triggerOutPinN) && outSel_r <= 3'h1 |-> !triggerOutPinN [*8] ##1 triggerOutPinN; endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_recov; $rose(triggerOutPinN) && outSel_r <= 3'h1 |-> triggerOutPinN [*8]; endproperty
  a_recov: assert property (p_recov) else $error("recovery");
  property p_cchain; $past(outSel_r, 2) == `TFT_TROUT_CCHAIN |-> triggerOutPinN == !$past(coreChainZero); endproperty
  a_cchain: assert property (p_cchain) else $error("core chain pin");
  property p_stall; $past(outSel_r, 2) == `TFT_TROUT_STALL
    |-> triggerOutPinN == !($past(stall_r, 2) && $past(cpuStalled)); endproperty
  a_stall: assert property (p_stall) else $error("stall pin");
  property p_manual; $past(inSel_r, 2) == `TFT_TRIN_MANUAL && !$past(trigWr, 2) |-> $stable(trigInLatch); endproperty
  a_manual: assert property (p_manual) else $error("manual latch moved");
  property p_level; $past(inSel_r, 2) == `TFT_TRIN_LEVEL && !$past(trigWr, 2) |-> trigInLatch == $past(triggerInPinN);
  endproperty
  a_level: assert property (p_level) else $error("level latch");
  c_pulse: cover property ($fell(triggerOutPinN));
  c_ref: cover property (refMsg);
  c_latch: cover property ($rose(trigInLatch));
endmodule : tft_checker
bind tft_top tft_checker chk (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_wdata, .chanMatch, .chanTrace, .chanHit, .chanTsAttach, .refMsg, .tsByte, .timestamp,
  .trigInLatch, .triggerInPinN, .coreChainZero, .cpuStalled, .triggerOutPinN);

// file: verif/test_trace_filter_trigger_unit.sv
`timescale 1ns/100ps
`include "tft_defs.svh"
module test_trace_filter_trigger_unit;
  import tft_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  tft_chan_t chanMatch = 4'h0, chanTrace, chanHit, chanTsAttach;
  logic refMsg, trigInLatch, triggerInPinN, triggerOutPinN;
  logic [7:0] tsByte;
  tft_ts_t timestamp, t0;
  logic trigInSetAct = 1'h0, trigInClrAct = 1'h0, coreTrigEvt = 1'h0, busAnTrigEvt = 1'h0, coreChainZero = 1'h0;
  logic modChainSet = 1'h0, modChainClr = 1'h0, cpuStalled = 1'h0, pinCmd = 1'h1, first = 1'h1;
  logic [15:0] pulseCnt, lastWidth, p0;
  logic [3:0] tinExp [4] = '{4'hd, 4'h5, 4'h8, 4'h0}; // Latch after rise, fall, clear, set
  int n_errors = 0, total_checks = 0, cyc = 0, gap = 0;
  tft_top DUT (.*);
  tft_la_model LA (.core_clk, .pinCmd, .triggerOutPinN, .triggerInPinN, .pulseCnt, .lastWidth);
  always #4 core_clk = ~core_clk;
  // Compare and count
  task check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Register write, address and data offered together
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do @(posedge core_clk); while ({s_axi_awready, s_axi_wready} !== 2'h3);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check(s_axi_bresp, r);
  endtask : axi_wr
  // Register read and compare
  task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge core_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check(s_axi_rdata, d);
    check(s_axi_rresp, r);
  endtask : axi_rd
  // Random match runs with a long idle stretch
  task trace_run(input logic [31:0] mode);
    tft_chan_t m, pm, nm, exT;
    m = 4'h0;
    pm = 4'h0;
    axi_wr(`TFT_OFF_CHMODE, mode, `TFT_RESP_OKAY);
    for (int i = 0; i < 600; i++)
    begin
      @(posedge core_clk);
      nm = ($urandom_range(0, 2) == 0) ? 4'($urandom) : m;
      if (i >= 590 || (i >= 200 && i < 520))
        nm = 4'h0;
      chanMatch <= nm;
      #1;
      exT = m & (mode[3:0] | ~pm);
      check(chanTrace, exT);
      check(chanHit, m);
      check(chanTsAttach, exT & mode[7:4]);
      if (exT != 4'h0)
      begin
        if (first || gap > 300)
          check(refMsg, 1'h1);
        else if (gap < 200)
          check(refMsg, 1'h0);
        first = 1'h0;
        gap = 0;
      end
      else
        gap++;
      pm = m;
      m = nm;
    end
  endtask : trace_run
  // Drive level-mode inputs and look at the pin
  task lvl(input logic [31:0] ctrl, input logic [3:0] stim, input logic exp);
    axi_wr(`TFT_OFF_CTRL, ctrl, `TFT_RESP_OKAY);
    {coreChainZero, modChainSet, modChainClr, cpuStalled} <= stim;
    @(posedge core_clk);
    {modChainSet, modChainClr} <= 2'h0;
    tick(4);
    check(triggerOutPinN, exp);
  endtask : lvl
  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(69062));
    tick(10);
    rst <= 1'h0;
    axi_rd(`TFT_OFF_CTRL, 32'h3, `TFT_RESP_OKAY);
    axi_rd(`TFT_OFF_PRESCALE, 32'h0, `TFT_RESP_OKAY);
    axi_rd(8'h40, 32'h0, `TFT_RESP_SLVERR);
    axi_wr(8'h40, 32'hffffffff, `TFT_RESP_SLVERR);
    trace_run(32'h52);
    trace_run(32'had);
    axi_wr(`TFT_OFF_PRESCALE, 32'h3, `TFT_RESP_OKAY);
    tick(4);
    t0 = timestamp;
    tick(40);
    check(timestamp - t0, 40'ha);
    axi_rd(`TFT_OFF_TSHI, 32'h0, `TFT_RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      axi_wr(`TFT_OFF_CTRL, 32'(k), `TFT_RESP_OKAY);
      pinCmd <= 1'h0;
      tick(5);
      axi_wr(`TFT_OFF_TRIGIN, 32'h0, `TFT_RESP_OKAY);
      pinCmd <= 1'h1;
      tick(5);
      check(trigInLatch, tinExp[k][3]);
      pinCmd <= 1'h0;
      tick(5);
      check(trigInLatch, tinExp[k][2]);
      trigInClrAct <= 1'h1;
      @(posedge core_clk);
      trigInClrAct <= 1'h0;
      tick(4);
      check(trigInLatch, tinExp[k][1]);
      trigInSetAct <= 1'h1;
      @(posedge core_clk);
      trigInSetAct <= 1'h0;
      tick(4);
      check(trigInLatch, tinExp[k][0]);
    end
    axi_wr(`TFT_OFF_TRIGIN, 32'h1, `TFT_RESP_OKAY);
    axi_rd(`TFT_OFF_TRIGIN, 32'h1, `TFT_RESP_OKAY);
    for (int s = 0; s < 2; s++)
    begin
      axi_wr(`TFT_OFF_CTRL, 32'h3 | 32'(s << 3), `TFT_RESP_OKAY);
      tick(20);
      p0 = pulseCnt;
      {coreTrigEvt, busAnTrigEvt} <= s ? 2'h2 : 2'h1;
      @(posedge core_clk);
      {coreTrigEvt, busAnTrigEvt} <= 2'h0;
      tick(20);
      check(pulseCnt - p0, 16'h0);
      {coreTrigEvt, busAnTrigEvt} <= s ? 2'h1 : 2'h2;
      tick(20);
      {coreTrigEvt, busAnTrigEvt} <= 2'h0;
      tick(30);
      check(pulseCnt - p0, 16'h2);
      check(lastWidth, 16'h8);
    end
    lvl(32'h13, 4'h8, 1'h0);
    lvl(32'h13, 4'h0, 1'h1);
    lvl(32'h1b, 4'h4, 1'h0);
    lvl(32'h1b, 4'h2, 1'h1);
    lvl(32'h1b, 4'h6, 1'h0);
    lvl(32'h27, 4'h1, 1'h0);
    lvl(32'h27, 4'h0, 1'h1);
    lvl(32'h23, 4'h1, 1'h1);
    lvl(32'h2b, 4'hf, 1'h1);
    wrap_up();
  end
endmodule : test_trace_filter_trigger_unit
